// *** verilog/tsm_pkg.sv ***
// Constants and decode functions shared by the timer slave-mode trigger controller.
package tsm_pkg;

   // Register byte offsets on the APB bus.
   localparam logic [11:0] CTRL_OFFSET = 12'h000;
   localparam logic [11:0] STAT_OFFSET = 12'h004;

   // Control register field positions.
   localparam int MODE_LSB   = 0;
   localparam int SRC_LSB    = 4;
   localparam int MSM_BIT    = 7;
   localparam int FILT_LSB   = 8;

   // Status register field positions.
   localparam int STAT_TRG_BIT  = 0;
   localparam int STAT_ETR_BIT  = 1;
   localparam int STAT_RUN_BIT  = 2;

   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Slave mode codes.
   localparam logic [2:0] MODE_OFF     = 3'h0;
   localparam logic [2:0] MODE_RESET   = 3'h4;
   localparam logic [2:0] MODE_GATED   = 3'h5;
   localparam logic [2:0] MODE_TRIGGER = 3'h6;
   localparam logic [2:0] MODE_EXTCLK  = 3'h7;

   // Trigger source codes.
   localparam logic [2:0] SRC_INTERNAL_TRIGGER_3  = 3'h3;
   localparam logic [2:0] SRC_EDGE1 = 3'h4;
   localparam logic [2:0] SRC_FILT1 = 3'h5;
   localparam logic [2:0] SRC_FILT2 = 3'h6;
   localparam logic [2:0] SRC_ETR   = 3'h7;

   localparam logic [3:0] FILT_OFF = 4'h0;

   // Sampling divider of the external trigger filter for a filter code.
   function automatic logic [3:0] filtDiv(input logic [3:0] code);
      logic [3:0] d;
      d = 4'h8;
      unique case (code)
         4'h0, 4'h1, 4'h2, 4'h3: d = 4'h1;
         4'h4, 4'h5:             d = 4'h2;
         4'h6, 4'h7:             d = 4'h4;
         default:                d = 4'h8;
      endcase
      return d;
   endfunction

   // Number of equal samples needed before the filtered level changes.
   function automatic logic [3:0] filtLen(input logic [3:0] code);
      logic [3:0] n;
      n = 4'h8;
      unique case (code)
         4'h0, 4'h1:             n = 4'h2;
         4'h2:                   n = 4'h4;
         4'h4, 4'h6, 4'h8:       n = 4'h6;
         default:                n = 4'h8;
      endcase
      return n;
   endfunction

endpackage

// *** verilog/tsm_etr_filter.sv ***
// Digital filter for the synchronised external trigger input.
`timescale 1ns/10ps
module tsm_etr_filter (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // Input level and filter setting
   input  wire logic       rawIn,
   input  wire logic [3:0] filterCode,
   // Filtered level
   output logic            filtOut
);

   logic [3:0] divCnt_q;
   logic [3:0] runCnt_q;
   logic       out_q;
   wire  [3:0] divVal   = tsm_pkg::filtDiv(filterCode);
   wire  [3:0] lenVal   = tsm_pkg::filtLen(filterCode);
   wire        filtOff  = (filterCode == tsm_pkg::FILT_OFF);
   wire        sampTick = (divCnt_q >= divVal - 4'h1);
   wire        differs  = (rawIn != out_q);

   assign filtOut = out_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         divCnt_q <= 4'h0;
      end else begin
         divCnt_q <= sampTick ? 4'h0 : divCnt_q + 4'h1;
      end
   end

   // A single sample equal to the output restarts the run, so glitches shorter than the window vanish.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         runCnt_q <= 4'h0;
         out_q    <= 1'b0;
      end else if (filtOff) begin
         runCnt_q <= 4'h0;
         out_q    <= rawIn;
      end else if (sampTick) begin
         if (!differs) begin
            runCnt_q <= 4'h0;
         // A run left over from a longer setting completes at once instead of wrapping.
         end else if (runCnt_q >= lenVal - 4'h1) begin
            runCnt_q <= 4'h0;
            out_q    <= rawIn;
         end else begin
            runCnt_q <= runCnt_q + 4'h1;
         end
      end
   end

   property p_filtBypass;
      @(posedge clk) disable iff (sys_rst)
      filterCode == 4'h0 |=> filtOut == $past(rawIn);
   endproperty
   a_filtBypass: assert property (p_filtBypass) else $error("filter bypass broken");

   property p_filtTwo;
      @(posedge clk) disable iff (sys_rst)
      filterCode == 4'h1 && rawIn != filtOut ##1
      filterCode == 4'h1 && rawIn != filtOut && $stable(rawIn) |=> filtOut == $past(rawIn);
   endproperty
   a_filtTwo: assert property (p_filtTwo) else $error("two-sample filter late");

   property p_filtSlow;
      @(posedge clk) disable iff (sys_rst)
      (filterCode == 4'h6 && rawIn != filtOut)[*8] |-> $stable(filtOut);
   endproperty
   a_filtSlow: assert property (p_filtSlow) else $error("div4 filter changed early");

   property p_filtCause;
      @(posedge clk) disable iff (sys_rst)
      $changed(filtOut) |-> filtOut == $past(rawIn);
   endproperty
   a_filtCause: assert property (p_filtCause) else $error("filter output without cause");

endmodule

// *** verilog/tsm_slave_ctrl.sv ***
// Timer slave-mode trigger controller with APB control and status registers.
// Functional notes
// - Gated mode lets the counter advance only while the selected trigger is high, never clearing it.
// - Trigger mode starts the counter on a rising edge of the selected trigger.
// - External clock mode 1 advances the counter once per rising edge of the selected trigger.
// - Source codes 0 to 3 select internal triggers 0 to 3.
// - Source codes 4, 5 and 6 select channel 1 edge detector, channel 1 and channel 2 filtered inputs.
// - Source code 7 selects the filtered external trigger.
// - The master/slave sync enable bit turns that mode on when 1 and has no effect when 0.
// - Filter code 0 disables filtering; codes 1 and 2 use divider 1 with 2 and 4 samples.
// - Filter codes 6, 7 and 8 use divider 4 with 6, divider 4 with 8, divider 8 with 6 samples.
// - Reset mode clears the counter with an update event on a rising trigger edge.
`timescale 1ns/10ps
module tsm_slave_ctrl (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Trigger sources
   input  wire logic        internal_trigger_0,
   input  wire logic        internal_trigger_1,
   input  wire logic        internal_trigger_2,
   input  wire logic        internal_trigger_3,
   input  wire logic        ch1_edge_detect,
   input  wire logic        ch1_filtered_input,
   input  wire logic        ch2_filtered_input,
   input  wire logic        extTriggerPin,
   // Counter core interface
   input  wire logic        counterEnable,
   output logic             countStep,
   output logic             counterClear,
   output logic             updateEvent,
   output logic             triggerEvent,
   output logic             master_slave_sync_enable
);

   logic [31:0] ctrl_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;
   logic        etrMeta_q;
   logic        etrSync_q;
   logic        trgPrev_q;
   logic        started_q;
   logic        countStep_q;
   logic        counterClear_q;
   logic        updateEvent_q;
   logic        triggerEvent_q;
   logic        filtered_external_trigger;
   logic        selected_trigger_input;

   wire [2:0] slaveMode = ctrl_q[tsm_pkg::MODE_LSB +: 3];
   wire [2:0] trigSrc   = ctrl_q[tsm_pkg::SRC_LSB +: 3];
   wire [3:0] filtCode  = ctrl_q[tsm_pkg::FILT_LSB +: 4];

   // APB decode; the slave never inserts wait states.
   wire setupPh  = psel && !penable;
   wire accessPh = psel && penable;
   wire hitCtrl  = (paddr[11:0] == tsm_pkg::CTRL_OFFSET) && (paddr[31:12] == 20'h0_0000);
   wire hitStat  = (paddr[11:0] == tsm_pkg::STAT_OFFSET) && (paddr[31:12] == 20'h0_0000);
   wire ctrlWr   = accessPh && pwrite && hitCtrl;

   assign pready  = 1'b1;
   assign prdata  = prdata_q;
   assign pslverr = pslverr_q & accessPh;

   wire [31:0] statWord = {29'h0000_0000, started_q, filtered_external_trigger,
                           selected_trigger_input};
   wire [31:0] readWord = hitCtrl ? ctrl_q : (hitStat ? statWord : 32'h0000_0000);
   wire [31:0] ctrlMask = 32'h0000_0FF7;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= tsm_pkg::CTRL_RESET;
      end else if (ctrlWr) begin
         ctrl_q <= pwdata & ctrlMask;
      end
   end

   // Read data is captured in the setup cycle so that it comes from a flip-flop.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setupPh) begin
         prdata_q  <= pwrite ? 32'h0000_0000 : readWord;
         pslverr_q <= !(hitCtrl || hitStat);
      end
   end

   // The pin is asynchronous to clk and is synchronised before the filter sees it.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         etrMeta_q <= 1'b0;
         etrSync_q <= 1'b0;
      end else begin
         etrMeta_q <= extTriggerPin;
         etrSync_q <= etrMeta_q;
      end
   end

   tsm_etr_filter u_filter (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .rawIn      (etrSync_q),
      .filterCode (filtCode),
      .filtOut    (filtered_external_trigger)
   );

   // Trigger source selection.
   always_comb begin
      unique case (trigSrc)
         3'h0:                selected_trigger_input = internal_trigger_0;
         3'h1:                selected_trigger_input = internal_trigger_1;
         3'h2:                selected_trigger_input = internal_trigger_2;
         tsm_pkg::SRC_INTERNAL_TRIGGER_3:   selected_trigger_input = internal_trigger_3;
         tsm_pkg::SRC_EDGE1:  selected_trigger_input = ch1_edge_detect;
         tsm_pkg::SRC_FILT1:  selected_trigger_input = ch1_filtered_input;
         tsm_pkg::SRC_FILT2:  selected_trigger_input = ch2_filtered_input;
         tsm_pkg::SRC_ETR:    selected_trigger_input = filtered_external_trigger;
      endcase
   end

   // The edge detector keeps running in every mode, so a source switched while the
   // slave mode is off cannot leave a stale previous level behind.
   wire trgRise = selected_trigger_input && !trgPrev_q;

   wire modeGated  = (slaveMode == tsm_pkg::MODE_GATED);
   wire modeTrig   = (slaveMode == tsm_pkg::MODE_TRIGGER);
   wire modeExtClk = (slaveMode == tsm_pkg::MODE_EXTCLK);
   wire modeReset  = (slaveMode == tsm_pkg::MODE_RESET);
   wire slaveOn    = modeGated || modeTrig || modeExtClk || modeReset;

   wire startedD = modeTrig && (started_q || trgRise);
   wire stepGate = modeGated ? (counterEnable && selected_trigger_input) : counterEnable;
   wire stepD    = modeExtClk ? trgRise : (modeTrig ? startedD : stepGate);
   wire clearD   = modeReset && trgRise;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trgPrev_q      <= 1'b0;
         started_q      <= 1'b0;
         countStep_q    <= 1'b0;
         counterClear_q <= 1'b0;
         updateEvent_q  <= 1'b0;
         triggerEvent_q <= 1'b0;
      end else begin
         trgPrev_q      <= selected_trigger_input;
         started_q      <= startedD;
         countStep_q    <= stepD;
         counterClear_q <= clearD;
         updateEvent_q  <= clearD;
         triggerEvent_q <= slaveOn && trgRise;
      end
   end

   assign countStep                = countStep_q;
   assign counterClear             = counterClear_q;
   assign updateEvent              = updateEvent_q;
   assign triggerEvent             = triggerEvent_q;
   assign master_slave_sync_enable = ctrl_q[tsm_pkg::MSM_BIT];

   property p_gatedRun;
      @(posedge clk) disable iff (sys_rst)
      modeGated && counterEnable && selected_trigger_input && !ctrlWr |=> countStep;
   endproperty
   a_gatedRun: assert property (p_gatedRun) else $error("gated mode did not count");

   property p_gatedHold;
      @(posedge clk) disable iff (sys_rst)
      modeGated && !selected_trigger_input && !ctrlWr |=> !countStep && !counterClear;
   endproperty
   a_gatedHold: assert property (p_gatedHold) else $error("gated mode counted or cleared");

   property p_trigStart;
      @(posedge clk) disable iff (sys_rst)
      modeTrig && trgRise && !ctrlWr |=> countStep && triggerEvent ##1 (countStep || !modeTrig);
   endproperty
   a_trigStart: assert property (p_trigStart) else $error("trigger mode did not start");

   property p_extClk;
      @(posedge clk) disable iff (sys_rst)
      modeExtClk && !ctrlWr |=> countStep == $past(trgRise);
   endproperty
   a_extClk: assert property (p_extClk) else $error("external clock step mismatch");

   property p_srcItr;
      @(posedge clk) disable iff (sys_rst)
      trigSrc == 3'h2 |-> selected_trigger_input == internal_trigger_2;
   endproperty
   a_srcItr: assert property (p_srcItr) else $error("internal trigger 2 not selected");

   property p_srcCh2;
      @(posedge clk) disable iff (sys_rst)
      trigSrc == 3'h6 |-> selected_trigger_input == ch2_filtered_input;
   endproperty
   a_srcCh2: assert property (p_srcCh2) else $error("channel 2 input not selected");

   property p_srcEtr;
      @(posedge clk) disable iff (sys_rst)
      trigSrc == 3'h7 |-> selected_trigger_input == filtered_external_trigger;
   endproperty
   a_srcEtr: assert property (p_srcEtr) else $error("external trigger not selected");

   property p_msmWrite;
      @(posedge clk) disable iff (sys_rst)
      ctrlWr |=> master_slave_sync_enable == $past(pwdata[7]);
   endproperty
   a_msmWrite: assert property (p_msmWrite) else $error("sync enable not written");

   property p_resetMode;
      @(posedge clk) disable iff (sys_rst)
      modeReset && trgRise && !ctrlWr |=> counterClear && updateEvent ##1 !counterClear;
   endproperty
   a_resetMode: assert property (p_resetMode) else $error("reset mode clear missing");

   c_gated: cover property (@(posedge clk) disable iff (sys_rst) modeGated ##1 countStep);
   c_trig:  cover property (@(posedge clk) disable iff (sys_rst) modeTrig && trgRise);
   c_ext:   cover property (@(posedge clk) disable iff (sys_rst) modeExtClk && countStep);
   c_clear: cover property (@(posedge clk) disable iff (sys_rst) counterClear);

endmodule

// *** bench/tsm_trig_model.sv ***
// Partner model of the trigger sources: other timers, channel inputs and external pin.
`timescale 1ns/10ps
module tsm_trig_model (
   // Clock
   input  wire logic       clk,
   // Stimulus from the bench
   input  wire logic [2:0] srcSel,
   input  wire logic       srcLevel,
   // Trigger lines toward the controller
   output logic [6:0]      trigLines,
   output logic            extPin
);
   // Unselected lines carry the inverse level, so a wrong selection shows at once.
   always @(posedge clk) begin
      for (int i = 0; i < 7; i++) begin
         trigLines[i] <= (srcSel == i[2:0]) ? srcLevel : ~srcLevel;
      end
      extPin <= (srcSel == 3'h7) ? srcLevel : ~srcLevel;
   end
endmodule

// *** bench/tsm_slave_ctrl_tb.sv ***
// Self-checking testbench for the timer slave-mode trigger controller.
`timescale 1ns/10ps
module tsm_slave_ctrl_tb;
   localparam logic [31:0] CTRL = 32'(tsm_pkg::CTRL_OFFSET);
   localparam logic [31:0] STAT = 32'(tsm_pkg::STAT_OFFSET);
   logic        clk, sysRst, psel, penable, pwrite, cntEn, lvl, err, pin;
   logic        pready, pslverr, countStep, counterClear, updateEvent, triggerEvent, msmOut;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [2:0]  mSel;
   logic [6:0]  trig;
   int          n_mismatch, cmp_count, cyc, nStep, nClr, nUpd, nTrg, s0, s1, k;

   tsm_trig_model u_tsm_trig_model (.clk(clk), .srcSel(mSel), .srcLevel(lvl),
      .trigLines(trig), .extPin(pin));
   tsm_slave_ctrl u_tsm_slave_ctrl (.clk(clk), .sys_rst(sysRst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .internal_trigger_0(trig[0]), .internal_trigger_1(trig[1]),
      .internal_trigger_2(trig[2]), .internal_trigger_3(trig[3]),
      .ch1_edge_detect(trig[4]), .ch1_filtered_input(trig[5]),
      .ch2_filtered_input(trig[6]), .extTriggerPin(pin), .counterEnable(cntEn),
      .countStep(countStep), .counterClear(counterClear), .updateEvent(updateEvent),
      .triggerEvent(triggerEvent), .master_slave_sync_enable(msmOut));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Events are counted on the falling edge, where the outputs have settled.
   always @(negedge clk) begin
      cyc++;
      nStep += (countStep === 1'b1);
      nClr += (counterClear === 1'b1);
      nUpd += (updateEvent === 1'b1);
      nTrg += (triggerEvent === 1'b1);
      if (cyc == 20000) begin
         n_mismatch++;
         complete_run;
      end
   end

   task automatic complete_run;
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // The source is always switched in a write that leaves the slave mode off first.
   task automatic cfg(input logic [2:0] m, input logic [2:0] s, input logic [3:0] f);
      mSel <= s;
      apb(1'b1, CTRL, {20'h0_0000, f, 1'b0, s, 1'b0, 3'h0});
      apb(1'b1, CTRL, {20'h0_0000, f, 1'b0, s, 1'b0, m});
   endtask

   task automatic t_regs;
      apb(1'b0, CTRL, 32'h0000_0000);
      check("ctrl reset", tsm_pkg::CTRL_RESET, rd);
      apb(1'b1, CTRL, 32'hFFFF_FFF8);
      apb(1'b0, CTRL, 32'h0000_0000);
      check("ctrl mask", 32'h0000_0FF0, rd);
      check("sync on", 32'h1, msmOut);
      apb(1'b1, CTRL, 32'h0000_0000);
      apb(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
      check("unmapped write err", 32'h1, err);
      apb(1'b0, 32'h0000_0010, 32'h0000_0000);
      check("unmapped read err", 32'h1, err);
      check("unmapped read data", 32'h0, rd);
      apb(1'b1, STAT, 32'hFFFF_FFFF);
      check("stat write err", 32'h0, err);
      apb(1'b0, CTRL, 32'h0000_0000);
      check("ctrl after stat write", 32'h0, rd);
      check("sync off", 32'h0, msmOut);
      $display("test regs done");
   endtask

   task automatic t_src;
      for (int s = 0; s < 8; s++) begin
         cfg(3'h0, s[2:0], 4'h0);
         for (int v = 0; v < 2; v++) begin
            lvl <= v[0];
            tick(8);
            apb(1'b0, STAT, 32'h0000_0000);
            check("stat source", (s == 7) ? {30'h0, v[0], v[0]} : {30'h0, ~v[0], v[0]}, rd);
         end
      end
      lvl <= 1'b0;
      $display("test sources done");
   endtask

   task automatic t_modes;
      cfg(tsm_pkg::MODE_GATED, 3'h1, 4'h0);
      cntEn <= 1'b1;
      tick(5);
      check("gated low", 32'h0, countStep);
      lvl <= 1'b1;
      tick(5);
      s0 = nStep;
      s1 = nClr;
      tick(10);
      check("gated run", 32'h0000_000A, nStep - s0);
      cntEn <= 1'b0;
      tick(5);
      check("gated no enable", 32'h0, countStep);
      cntEn <= 1'b1;
      lvl <= 1'b0;
      tick(5);
      lvl <= 1'b1;
      tick(5);
      check("gated resume", 32'h1, countStep);
      check("gated no clear", 32'h0, nClr - s1);
      lvl <= 1'b0;
      cfg(tsm_pkg::MODE_OFF, 3'h1, 4'h0);
      cfg(tsm_pkg::MODE_TRIGGER, 3'h2, 4'h0);
      cntEn <= 1'b0;
      tick(5);
      check("trig idle", 32'h0, countStep);
      s0 = nTrg;
      lvl <= 1'b1;
      tick(5);
      check("trig start", 32'h1, countStep);
      check("trig event", 32'h1, nTrg - s0);
      lvl <= 1'b0;
      tick(5);
      apb(1'b0, STAT, 32'h0000_0000);
      check("trig stays", 32'h1, countStep);
      check("trig stat", 32'h0000_0006, rd);
      cfg(tsm_pkg::MODE_OFF, 3'h2, 4'h0);
      cfg(tsm_pkg::MODE_EXTCLK, 3'h3, 4'h0);
      tick(5);
      s0 = nStep;
      s1 = nTrg;
      repeat (5) begin
         lvl <= 1'b1;
         tick(3);
         lvl <= 1'b0;
         tick(3);
      end
      tick(5);
      check("ext clock steps", 32'h0000_0005, nStep - s0);
      check("ext clock events", 32'h0000_0005, nTrg - s1);
      cfg(tsm_pkg::MODE_OFF, 3'h3, 4'h0);
      cfg(tsm_pkg::MODE_RESET, 3'h4, 4'h0);
      cntEn <= 1'b1;
      tick(5);
      s0 = nClr;
      s1 = nUpd;
      repeat (3) begin
         lvl <= 1'b1;
         tick(2);
         lvl <= 1'b0;
         tick(2);
      end
      tick(5);
      check("reset clears", 32'h0000_0003, nClr - s0);
      check("reset updates", 32'h0000_0003, nUpd - s1);
      check("reset counts", 32'h1, countStep);
      cfg(tsm_pkg::MODE_OFF, 3'h4, 4'h0);
      $display("test modes done");
   endtask

   // A pulse of (n-1)*d cycles never yields n equal samples, so it must vanish; code 0 sends a one-cycle pulse that must pass.
   task automatic t_filt(input logic [3:0] code, input int d, input int n);
      int g;
      g = (code == 4'h0) ? 1 : (n - 1) * d;
      cfg(tsm_pkg::MODE_EXTCLK, 3'h7, code);
      tick(n * d * 2 + 10);
      s0 = nTrg;
      lvl <= 1'b1;
      tick(g);
      lvl <= 1'b0;
      tick(n * d * 2 + 10);
      check("filter glitch", 32'(code == 4'h0), nTrg - s0);
      lvl <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (triggerEvent !== 1'b1 && k < 300);
      check("filter delay", 32'h1, 32'(k >= (n - 1) * d + 3 && k <= n * d + 8));
      lvl <= 1'b0;
      tick(n * d * 2 + 10);
      cfg(tsm_pkg::MODE_OFF, 3'h7, code);
      $display("test filter %h done", code);
   endtask

   initial begin
      sysRst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0000_0000;
      pwdata = 32'h0000_0000;
      cntEn = 1'b0;
      lvl = 1'b0;
      mSel = 3'h0;
      repeat (6) @(posedge clk);
      sysRst <= 1'b0;
      t_regs;
      t_src;
      t_modes;
      t_filt(4'h0, 1, 1);
      t_filt(4'h1, 1, 2);
      t_filt(4'h2, 1, 4);
      t_filt(4'h3, 1, 8);
      t_filt(4'h4, 2, 6);
      t_filt(4'h5, 2, 8);
      t_filt(4'h6, 4, 6);
      t_filt(4'h7, 4, 8);
      t_filt(4'h8, 8, 6);
      t_filt(4'hF, 8, 8);
      complete_run;
   end
endmodule
